// ==== hdl/tcc_pkg.sv ====
// package: register map, field positions, reset values and carriers for the capture/compare block
package tcc_pkg;

   // ------------------------------------------------------------
   // register word addresses (avalon word index)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL_A = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B = 4'h1;
   localparam logic [3:0] ADDR_CMP_STAT = 4'h2;
   localparam logic [3:0] ADDR_CNT_LO = 4'h3;
   localparam logic [3:0] ADDR_CNT_HI = 4'h4;
   localparam logic [3:0] ADDR_CAP_LO = 4'h5;
   localparam logic [3:0] ADDR_CAP_HI = 4'h6;
   localparam logic [3:0] ADDR_CMPA_LO = 4'h7;
   localparam logic [3:0] ADDR_CMPA_HI = 4'h8;
   localparam logic [3:0] ADDR_CMPB_LO = 4'h9;
   localparam logic [3:0] ADDR_CMPB_HI = 4'ha;
   localparam logic [3:0] ADDR_FLAGS = 4'hb;
   localparam logic [3:0] ADDR_IRQ_EN = 4'hc;
   localparam logic [3:0] ADDR_STATUS = 4'hd;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   // ctrl_a: [1:0] mode lo, [3:2] cmp_b mode bits, [5:4] cmp_a mode bits
   localparam int CA_WGM_LO = 0;
   localparam int CA_COM_B = 2;
   localparam int CA_COM_A = 4;
   // ctrl_b: [1:0] mode hi, [2] edge select, [3] filter enable, [4] force a, [5] force b
   localparam int CB_WGM_HI = 0;
   localparam int CB_EDGE = 2;
   localparam int CB_FILT = 3;
   localparam int CB_FOC_A = 4;
   localparam int CB_FOC_B = 5;
   // comparator control/status: [0] capture select
   localparam int CS_COMPARATOR_CAPTURE_SELECT = 0;
   // flags / irq enables: [0] capture, [1] compare a, [2] compare b
   localparam int FL_CAP = 0;
   localparam int FL_CMPA = 1;
   localparam int FL_CMPB = 2;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [1:0] FILT_LEN = 2'h3; // four equal samples: current plus three held
   localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avm_req_t;

   typedef struct packed
   {
      logic [31:0] readdata;
      logic waitrequest;
   } avm_rsp_t;

endpackage

// ==== hdl/timer16_capture_compare_units.sv ====
// capture and compare units of a 16-bit timer, with avalon-mm register access
`timescale 1ns/1ps
module timer16_capture_compare_units
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // register bus
   input wire avm_req_t avm_req_i,
   output avm_rsp_t avm_rsp_o,
   // counter unit interface
   input wire logic [15:0] counter_value_i,
   input wire logic timer_tick_i,
   input wire logic count_up_i,
   output logic counter_write_o,
   output logic [15:0] counter_wdata_o,
   // event inputs
   input wire logic capture_input_pin_i,
   input wire logic comparator_output_i,
   // compare outputs and requests
   output logic [1:0] compare_output_bit_o,
   output logic [1:0] compare_match_o,
   output logic irq_capture_o,
   output logic [1:0] irq_compare_o,
   output logic [3:0] waveform_mode_bits_o,
   // interrupt acknowledge from the vector unit
   input wire logic ack_capture_i,
   input wire logic [1:0] ack_compare_i
);

   // ------------------------------------------------------------
   // register bus decode
   // ------------------------------------------------------------
   logic wr_s;
   logic rd_s;
   logic [7:0] wb_s;
   logic [7:0] ctrl_a_q;
   logic [5:0] ctrl_b_q;
   logic comparator_capture_select_q;
   logic [7:0] high_byte_latch_q;
   logic [15:0] capture_value_reg_q;
   logic [2:0] flags_q;
   logic [2:0] irq_en_q;
   logic [15:0] cmp_q [2];
   logic [15:0] cmp_buf_q [2];
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic [3:0] wgm_s;
   logic pwm_s;
   logic icr_top_s;
   logic [1:0] foc_s;

   assign wr_s = avm_req_i.write;
   assign rd_s = avm_req_i.read & ~rvalid_q;
   assign wb_s = avm_req_i.writedata[7:0];
   // writes complete at once, reads after one registered cycle
   assign avm_rsp_o = {rdata_q, avm_req_i.read & ~rvalid_q};

   assign wgm_s = {ctrl_b_q[CB_WGM_HI +: 2], ctrl_a_q[CA_WGM_LO +: 2]};
   assign waveform_mode_bits_o = wgm_s;
   // modes 0, 4 and 12 are non-pwm, 13 reserved; all others pwm
   assign pwm_s = ~(wgm_s == 4'h0 || wgm_s == 4'h4 || wgm_s == 4'hc || wgm_s == 4'hd);
   assign icr_top_s = (wgm_s == 4'h8 || wgm_s == 4'ha || wgm_s == 4'hc || wgm_s == 4'he);

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_a_q <= RST_BYTE;
         ctrl_b_q <= 6'h00;
         comparator_capture_select_q <= 1'b0;
         irq_en_q <= 3'h0;
      end
      else if (wr_s)
      begin
         unique case (avm_req_i.address)
            ADDR_CTRL_A: ctrl_a_q <= wb_s;
            ADDR_CTRL_B: ctrl_b_q <= {2'b00, wb_s[3:0]};
            ADDR_CMP_STAT: comparator_capture_select_q <= wb_s[CS_COMPARATOR_CAPTURE_SELECT];
            ADDR_IRQ_EN: irq_en_q <= wb_s[2:0];
            default: ;
         endcase
      end
   end

   // force strobes act in the write cycle and are never stored
   assign foc_s[0] = wr_s && avm_req_i.address == ADDR_CTRL_B && wb_s[CB_FOC_A] && !pwm_s;
   assign foc_s[1] = wr_s && avm_req_i.address == ADDR_CTRL_B && wb_s[CB_FOC_B] && !pwm_s;

   // counter write: upper byte taken from the shared latch
   assign counter_write_o = wr_s && avm_req_i.address == ADDR_CNT_LO;
   assign counter_wdata_o = {high_byte_latch_q, wb_s};

   // ------------------------------------------------------------
   // shared high byte latch
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         high_byte_latch_q <= RST_BYTE;
      else if (wr_s && (avm_req_i.address == ADDR_CNT_HI || avm_req_i.address == ADDR_CAP_HI ||
               avm_req_i.address == ADDR_CMPA_HI || avm_req_i.address == ADDR_CMPB_HI))
         high_byte_latch_q <= wb_s;
      else if (rd_s && avm_req_i.address == ADDR_CAP_LO)
         high_byte_latch_q <= capture_value_reg_q[15:8];
      else if (rd_s && avm_req_i.address == ADDR_CNT_LO)
         high_byte_latch_q <= counter_value_i[15:8];
   end

   // ------------------------------------------------------------
   // capture input: synchroniser, noise filter, edge detector
   // ------------------------------------------------------------
   logic [2:0] sync_q;
   logic src_s;
   logic [2:0] hist_q;
   logic filt_q;
   logic sel_q;
   logic prev_q;
   logic cap_trig_s;
   logic cap_in_s;

   // the pin path already carries the port-driven level, so software capture needs no extra path
   assign src_s = comparator_capture_select_q ? comparator_output_i : capture_input_pin_i;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         sync_q <= 3'h0;
      else
         sync_q <= {sync_q[1:0], src_s};
   end

   // stage 1 is read only by stage 2; the level counts once stages 2 and 3 agree
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         sel_q <= 1'b0;
      else if (sync_q[1] == sync_q[2])
         sel_q <= sync_q[2];
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         hist_q <= 3'h0;
         filt_q <= 1'b0;
      end
      else
      begin
         hist_q <= {hist_q[1:0], sel_q};
         if (hist_q == {3{sel_q}})
            filt_q <= sel_q;
      end
   end

   assign cap_in_s = ctrl_b_q[CB_FILT] ? filt_q : sel_q;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         prev_q <= 1'b0;
      else
         prev_q <= cap_in_s;
   end

   // a source switch changes cap_in_s and may fire here; software clears the flag afterwards
   assign cap_trig_s = !icr_top_s && (ctrl_b_q[CB_EDGE] ? (cap_in_s && !prev_q)
                                                         : (!cap_in_s && prev_q));

   // capture value register: overwritten by every capture
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         capture_value_reg_q <= RST_WORD;
      else if (cap_trig_s)
         capture_value_reg_q <= counter_value_i;
      else if (wr_s && icr_top_s && avm_req_i.address == ADDR_CAP_LO)
         capture_value_reg_q <= {high_byte_latch_q, wb_s};
   end

   // ------------------------------------------------------------
   // compare channels
   // ------------------------------------------------------------
   logic block_q;
   logic [1:0] match_pend_q;
   logic [1:0] obit_q;
   logic at_top_s;
   logic at_bottom_s;
   logic [15:0] top_s;

   always_comb
   begin
      unique case (wgm_s)
         4'h1, 4'h5: top_s = 16'h00ff;
         4'h2, 4'h6: top_s = 16'h01ff;
         4'h3, 4'h7: top_s = 16'h03ff;
         4'h8, 4'ha, 4'hc, 4'he: top_s = capture_value_reg_q;
         4'h4, 4'h9, 4'hb, 4'hf: top_s = cmp_q[0];
         default: top_s = CNT_MAX;
      endcase
   end

   assign at_top_s = counter_value_i == top_s;
   assign at_bottom_s = counter_value_i == RST_WORD;

   // a counter write blocks matches until the next timer clock has passed
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         block_q <= 1'b0;
      else if (counter_write_o)
         block_q <= 1'b1;
      else if (timer_tick_i)
         block_q <= 1'b0;
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++)
      begin : g_ch
         logic wr_lo_s;
         logic [1:0] com_s;
         logic load_s;
         assign wr_lo_s = wr_s && avm_req_i.address == (ch == 0 ? ADDR_CMPA_LO : ADDR_CMPB_LO);
         assign com_s = ch == 0 ? ctrl_a_q[CA_COM_A +: 2] : ctrl_a_q[CA_COM_B +: 2];
         // fast pwm loads at bottom, dual slope at top
         assign load_s = timer_tick_i && ((wgm_s inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf}) ? at_bottom_s
                                                                                        : at_top_s);
         assign compare_match_o[ch] = (counter_value_i == cmp_q[ch]) && !block_q;

         always_ff @(posedge core_clk_i)
         begin
            if (sys_rst_i)
            begin
               cmp_q[ch] <= RST_WORD;
               cmp_buf_q[ch] <= RST_WORD;
            end
            else
            begin
               if (wr_lo_s && pwm_s)
                  cmp_buf_q[ch] <= {high_byte_latch_q, wb_s};
               if (wr_lo_s && !pwm_s)
                  cmp_q[ch] <= {high_byte_latch_q, wb_s};
               else if (pwm_s && load_s)
                  cmp_q[ch] <= cmp_buf_q[ch];
            end
         end

         // flag is set at the timer clock following the match
         always_ff @(posedge core_clk_i)
         begin
            if (sys_rst_i)
               match_pend_q[ch] <= 1'b0;
            else if (timer_tick_i)
               match_pend_q[ch] <= compare_match_o[ch];
         end

         // output bit: match action in non-pwm modes, reset to zero, kept on mode change
         always_ff @(posedge core_clk_i)
         begin
            if (sys_rst_i)
               obit_q[ch] <= 1'b0;
            else if (foc_s[ch] || (!pwm_s && timer_tick_i && compare_match_o[ch]))
            begin
               unique case (com_s)
                  2'b00: obit_q[ch] <= obit_q[ch];
                  2'b01: obit_q[ch] <= ~obit_q[ch];
                  2'b10: obit_q[ch] <= 1'b0;
                  2'b11: obit_q[ch] <= 1'b1;
               endcase
            end
            else if (pwm_s && timer_tick_i && com_s[1])
            begin
               if (compare_match_o[ch])
                  obit_q[ch] <= (com_s[0] ~^ count_up_i);
               else if (at_bottom_s)
                  obit_q[ch] <= ~com_s[0];
            end
         end
      end
   endgenerate

   assign compare_output_bit_o = obit_q;

   // ------------------------------------------------------------
   // flags: hardware set wins over clear
   // ------------------------------------------------------------
   logic [2:0] set_s;
   logic [2:0] clr_s;
   assign set_s = {timer_tick_i & match_pend_q[1], timer_tick_i & match_pend_q[0], cap_trig_s};
   assign clr_s = {ack_compare_i, ack_capture_i} |
                  ((wr_s && avm_req_i.address == ADDR_FLAGS) ? wb_s[2:0] : 3'h0);

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
         flags_q <= 3'h0;
      else
         flags_q <= (flags_q & ~clr_s) | set_s;
   end

   assign irq_capture_o = flags_q[FL_CAP] & irq_en_q[FL_CAP];
   assign irq_compare_o = flags_q[FL_CMPB:FL_CMPA] & irq_en_q[FL_CMPB:FL_CMPA];

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         rdata_q <= BUS_UNMAPPED;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= rd_s;
         rdata_q <= BUS_UNMAPPED;
         if (rd_s)
         begin
            unique case (avm_req_i.address)
               ADDR_CTRL_A: rdata_q <= {24'h0, ctrl_a_q};
               ADDR_CTRL_B: rdata_q <= {26'h0, ctrl_b_q};
               ADDR_CMP_STAT: rdata_q <= {31'h0, comparator_capture_select_q};
               ADDR_CNT_LO: rdata_q <= {24'h0, counter_value_i[7:0]};
               ADDR_CNT_HI, ADDR_CAP_HI: rdata_q <= {24'h0, high_byte_latch_q};
               ADDR_CAP_LO: rdata_q <= {24'h0, capture_value_reg_q[7:0]};
               ADDR_CMPA_LO: rdata_q <= {24'h0, pwm_s ? cmp_buf_q[0][7:0] : cmp_q[0][7:0]};
               ADDR_CMPA_HI: rdata_q <= {24'h0, pwm_s ? cmp_buf_q[0][15:8] : cmp_q[0][15:8]};
               ADDR_CMPB_LO: rdata_q <= {24'h0, pwm_s ? cmp_buf_q[1][7:0] : cmp_q[1][7:0]};
               ADDR_CMPB_HI: rdata_q <= {24'h0, pwm_s ? cmp_buf_q[1][15:8] : cmp_q[1][15:8]};
               ADDR_FLAGS: rdata_q <= {29'h0, flags_q};
               ADDR_IRQ_EN: rdata_q <= {29'h0, irq_en_q};
               ADDR_STATUS: rdata_q <= {28'h0, obit_q, filt_q, sel_q};
               default: rdata_q <= BUS_UNMAPPED;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_cap;
      cap_trig_s;
   endsequence

   sequence s_match_a;
      timer_tick_i && compare_match_o[0];
   endsequence

   sequence s_pend_a;
      timer_tick_i && match_pend_q[0];
   endsequence

   a_cap_copies_count: assert property (s_cap |=> capture_value_reg_q == $past(counter_value_i))
      else $error("capture value not copied");
   a_cap_sets_flag: assert property (s_cap |=> flags_q[FL_CAP])
      else $error("capture flag not set");
   a_cap_top_off: assert property (icr_top_s && !(wr_s && avm_req_i.address == ADDR_CAP_LO)
                                   |=> $stable(capture_value_reg_q))
      else $error("capture in icr top mode");
   a_filter_hold: assert property (ctrl_b_q[CB_FILT] && $changed(filt_q) |-> $past(hist_q) == {3{$past(sel_q)}})
      else $error("filter changed early");
   a_block_match: assert property (counter_write_o |=> !compare_match_o[0] && !compare_match_o[1])
      else $error("match not blocked");
   a_match_pend: assert property (s_match_a |=> match_pend_q[0])
      else $error("compare match not held");
   a_flag_delay: assert property (s_pend_a |=> flags_q[FL_CMPA])
      else $error("compare flag late");
   a_force_noflag: assert property (foc_s[0] && !match_pend_q[0] && !flags_q[FL_CMPA] |=> !flags_q[FL_CMPA])
      else $error("force set flag");
   a_direct_write: assert property (!pwm_s && wr_s && avm_req_i.address == ADDR_CMPA_LO
                                    |=> cmp_q[0] == {$past(high_byte_latch_q), $past(wb_s)})
      else $error("compare write wrong");

endmodule // timer16_capture_compare_units

// ==== test/tcc_counter_model.sv ====
// counter unit model that feeds count value, ticks and direction to the timer
`timescale 1ns/1ps
module tcc_counter_model
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // control from the bench and the timer
   input wire logic run_i,
   input wire logic counter_write_i,
   input wire logic [15:0] counter_wdata_i,
   // count outputs
   output logic [15:0] counter_value_o,
   output logic timer_tick_o,
   output logic count_up_o
);
   // ------------------------------------------------------------
   // timer clock
   // ------------------------------------------------------------
   // one tick every second clock while running; a stopped timer gives no tick at all
   always_ff @(posedge core_clk_i)
      if (sys_rst_i)
         timer_tick_o <= 1'b0;
      else
         timer_tick_o <= run_i & ~timer_tick_o;
   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   // a cpu write overrides counting; only up-counting is modelled
   always_ff @(posedge core_clk_i)
      if (sys_rst_i)
         counter_value_o <= 16'h0000;
      else if (counter_write_i)
         counter_value_o <= counter_wdata_i;
      else if (timer_tick_o)
         counter_value_o <= counter_value_o + 16'h0001;
   assign count_up_o = 1'b1;
endmodule // tcc_counter_model

// ==== test/timer16_capture_compare_units_tb.sv ====
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
module timer16_capture_compare_units_tb;
   import tcc_pkg::*;
   logic core_clk_i, sys_rst_i, run, cw, up, tick, pin, cmp, irqc, ackc;
   avm_req_t req;
   avm_rsp_t rsp;
   logic [15:0] cnt, cwd;
   logic [1:0] ocb, cm, irqm, ackm;
   logic [3:0] wgm;
   int fail_count, compares, l0, l1;
   logic [3:0] ra [6] = '{ADDR_CTRL_A, ADDR_IRQ_EN, ADDR_CMP_STAT, ADDR_CMP_STAT, 4'he, ADDR_CAP_LO};
   logic [7:0] rw [6] = '{8'h30, 8'h07, 8'h01, 8'h00, 8'h55, 8'h34};
   logic [7:0] rx [6] = '{8'h30, 8'h07, 8'h01, 8'h00, 8'h00, 8'h00};

   timer16_capture_compare_units u_timer16_capture_compare_units (.core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i), .avm_req_i(req), .avm_rsp_o(rsp), .counter_value_i(cnt),
      .timer_tick_i(tick), .count_up_i(up), .counter_write_o(cw), .counter_wdata_o(cwd),
      .capture_input_pin_i(pin), .comparator_output_i(cmp), .compare_output_bit_o(ocb),
      .compare_match_o(cm), .irq_capture_o(irqc), .irq_compare_o(irqm), .waveform_mode_bits_o(wgm),
      .ack_capture_i(ackc), .ack_compare_i(ackm));
   tcc_counter_model u_tcc_counter_model (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .run_i(run),
      .counter_write_i(cw), .counter_wdata_i(cwd), .counter_value_o(cnt), .timer_tick_o(tick),
      .count_up_o(up));

   // ------------------------------------------------------------
   // clock and helpers
   // ------------------------------------------------------------
   initial
   begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   task automatic complete_run();
      $display("fails %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   // request held until waitrequest is sampled low at a rising edge; data taken at that edge
   task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge core_clk_i);
      req.address <= a;
      req.write <= w;
      req.read <= ~w;
      req.writedata <= {24'h00_0000, d};
      do
      begin
         @(posedge core_clk_i);
         n++;
         if (n > 50)
         begin
            fail_count++;
            complete_run();
         end
      end
      while (rsp.waitrequest !== 1'b0);
      q = rsp.readdata[7:0];
      req <= '0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(a, 1'b0, 8'h00, q);
      chk(16'(q), 16'(e));
   endtask

   // upper byte first, the lower address commits the word
   task automatic w16(input logic [3:0] hi, input logic [15:0] v);
      wr(hi, v[15:8]);
      wr(hi - 4'h1, v[7:0]);
   endtask

   // cycles from an input change until the capture request rises
   task automatic lat(output int l);
      l = 0;
      do
      begin
         @(negedge core_clk_i);
         l++;
         if (l > 40)
         begin
            fail_count++;
            complete_run();
         end
      end
      while (irqc !== 1'b1);
   endtask

   task automatic pin_pulse();
      @(posedge core_clk_i);
      pin <= ~pin;
      cyc(2);
      pin <= ~pin;
      cyc(12);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      fail_count = 0;
      compares = 0;
      sys_rst_i = 1'b1;
      req = '0;
      run = 1'b0;
      pin = 1'b0;
      cmp = 1'b0;
      ackc = 1'b0;
      ackm = 2'b00;
      cyc(20);
      sys_rst_i <= 1'b0;
      chk(16'(ocb), 16'h0000);
      for (int a = 0; a < 14; a++)
         rd(4'(a), 8'h00);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         wr(ra[i], rw[i]);
         rd(ra[i], rx[i]);
      end
      wr(ADDR_CTRL_A, 8'h00);
      $display("test rows done");
      // compare match, delayed flag, write-one clear and acknowledge clear
      w16(ADDR_CMPA_HI, 16'h0010);
      rd(ADDR_CMPA_HI, 8'h00);
      w16(ADDR_CNT_HI, 16'h000c);
      run <= 1'b1;
      l0 = 0;
      while (cm[0] !== 1'b1 && l0 < 40)
      begin
         @(negedge core_clk_i);
         l0++;
      end
      chk(cnt, 16'h0010);
      cyc(4);
      run <= 1'b0;
      @(negedge core_clk_i);
      chk(16'(irqm), 16'h0001);
      rd(ADDR_FLAGS, 8'h02);
      wr(ADDR_FLAGS, 8'h02);
      rd(ADDR_FLAGS, 8'h00);
      w16(ADDR_CNT_HI, 16'h000f);
      run <= 1'b1;
      lat_cmp : for (int i = 0; i < 40 && irqm[0] !== 1'b1; i++)
         @(negedge core_clk_i);
      chk(16'(irqm), 16'h0001);
      @(posedge core_clk_i);
      run <= 1'b0;
      ackm <= 2'b01;
      @(posedge core_clk_i);
      ackm <= 2'b00;
      rd(ADDR_FLAGS, 8'h00);
      $display("test compare done");
      // counter written equal to the compare value while stopped, then restarted
      w16(ADDR_CNT_HI, 16'h0010);
      cyc(3);
      chk(16'(cm), 16'h0000);
      run <= 1'b1;
      cyc(6);
      run <= 1'b0;
      rd(ADDR_FLAGS, 8'h00);
      $display("test blocking done");
      // forced compare in normal and clear-on-match modes
      wr(ADDR_CTRL_A, 8'h10);
      wr(ADDR_CTRL_B, 8'h10);
      cyc(2);
      chk(16'(ocb), 16'h0001);
      rd(ADDR_FLAGS, 8'h00);
      wr(ADDR_CTRL_B, 8'h01);
      cyc(2);
      chk(16'(ocb), 16'h0001);
      chk(16'(wgm), 16'h0004);
      wr(ADDR_CTRL_B, 8'h11);
      cyc(2);
      chk(16'(ocb), 16'h0000);
      $display("test force done");
      // pwm mode: a compare write lands in the buffer, not the comparator
      w16(ADDR_CNT_HI, 16'h0021);
      run <= 1'b1;
      @(posedge core_clk_i);
      run <= 1'b0;
      cyc(3);
      wr(ADDR_CTRL_A, 8'h01);
      wr(ADDR_CTRL_B, 8'h01);
      w16(ADDR_CMPB_HI, 16'h0022);
      cyc(2);
      chk(16'(cm), 16'h0000);
      rd(ADDR_CMPB_LO, 8'h22);
      // one tick at bottom loads the buffers, one more tick lands on the new value
      w16(ADDR_CNT_HI, 16'h0000);
      run <= 1'b1;
      cyc(2);
      run <= 1'b0;
      w16(ADDR_CNT_HI, 16'h0021);
      run <= 1'b1;
      cyc(2);
      run <= 1'b0;
      cyc(1);
      chk(16'(cm), 16'h0002);
      $display("test buffer done");
      // captures: rising, overwrite by falling, filter delay, filter glitch
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_CTRL_B, 8'h04);
      wr(ADDR_FLAGS, 8'h07);
      w16(ADDR_CNT_HI, 16'h1234);
      @(posedge core_clk_i);
      pin <= 1'b1;
      lat(l0);
      chk(16'(irqc), 16'h0001);
      w16(ADDR_CNT_HI, 16'h5678);
      wr(ADDR_CTRL_B, 8'h00);
      wr(ADDR_FLAGS, 8'h01);
      @(posedge core_clk_i);
      pin <= 1'b0;
      lat(l1);
      rd(ADDR_CAP_LO, 8'h78);
      rd(ADDR_CAP_HI, 8'h56);
      @(posedge core_clk_i);
      ackc <= 1'b1;
      @(posedge core_clk_i);
      ackc <= 1'b0;
      wr(ADDR_CTRL_B, 8'h0c);
      rd(ADDR_FLAGS, 8'h00);
      @(posedge core_clk_i);
      pin <= 1'b1;
      lat(l1);
      chk(16'(l1), 16'(l0 + 4));
      wr(ADDR_CTRL_B, 8'h08);
      wr(ADDR_FLAGS, 8'h01);
      @(posedge core_clk_i);
      pin <= 1'b0;
      cyc(3);
      pin <= 1'b1;
      cyc(12);
      chk(16'(irqc), 16'h0000);
      $display("test capture done");
      // comparator as source; the pin is then ignored
      wr(ADDR_CTRL_B, 8'h04);
      wr(ADDR_CMP_STAT, 8'h01);
      wr(ADDR_FLAGS, 8'h01);
      @(posedge core_clk_i);
      cmp <= 1'b1;
      lat(l1);
      chk(16'(irqc), 16'h0001);
      wr(ADDR_FLAGS, 8'h01);
      pin_pulse();
      chk(16'(irqc), 16'h0000);
      wr(ADDR_CMP_STAT, 8'h00);
      wr(ADDR_FLAGS, 8'h01);
      $display("test source done");
      // capture register as top: writable, capture disabled
      wr(ADDR_CTRL_B, 8'h07);
      cyc(1);
      chk(16'(wgm), 16'h000c);
      w16(ADDR_CAP_HI, 16'habcd);
      rd(ADDR_CAP_LO, 8'hcd);
      rd(ADDR_CAP_HI, 8'hab);
      wr(ADDR_FLAGS, 8'h01);
      pin_pulse();
      rd(ADDR_FLAGS, 8'h00);
      $display("test top mode done");
      // mid-run reset clears a forced output bit
      wr(ADDR_CTRL_A, 8'h30);
      wr(ADDR_CTRL_B, 8'h17);
      cyc(1);
      chk(16'(ocb), 16'h0001);
      sys_rst_i <= 1'b1;
      cyc(2);
      sys_rst_i <= 1'b0;
      chk(16'(ocb), 16'h0000);
      $display("test reset again done");
      complete_run();
   end
endmodule // timer16_capture_compare_units_tb
